// *** sgc_consts.svh ***
// constants of the shading gain calibration engine
// Functional notes
// R01 - separate gain sets for single-line and other modes
// R02 - narrow region computes inside only, writes whole
// R03 - pixels outside region keep previous active values
// R04 - start register write, with or without offset
// R05 - offset variant corrects samples before gain computation
// R06 - collect at least 128 lines before computing
// R07 - host supplies at least 128 trigger cycles
// R08 - line and data valid toggle; data meaningless
// R09 - no command acknowledge during calibration acquisitions
// R10 - host withholds commands for 128 line periods
// R11 - average every pixel over collected lines
// R12 - brightest averaged pixel becomes reference level
// R13 - gain raises each pixel to reference level
// R14 - gain set overwrites user file in storage
// R15 - user file activated after generation completes
// R16 - user or factory file selectable for activation
// R17 - activation copies file into working memory
// R18 - activated file reloaded after every reset
// R19 - activation happens on bulk data register write
// R20 - mode selects offset, gain or both corrections
// R21 - stored gain multiplies each incoming pixel value
`ifndef SGC_CONSTS_SVH
`define SGC_CONSTS_SVH
`define SGC_PIX_W 12
`define SGC_GAIN_W 16
`define SGC_GAIN_FRAC 12
`define SGC_GAIN_ONE 16'h1000
`define SGC_GAIN_MAX 16'hFFFF
`define SGC_PIX_MAX 12'hFFF
`define SGC_NCAL 128
`define SGC_NCAL_LOG 7
`define SGC_NCAL_LAST 7'h7F
`define SGC_MODE_OFF_BIT 0
`define SGC_MODE_GAIN_BIT 1
`endif

// *** sgc_pkg.sv ***
// types of the shading gain calibration engine
`include "sgc_consts.svh"
package sgc_pkg;
   typedef struct packed
   {
      logic lval;
      logic dval;
      logic [`SGC_PIX_W-1:0] data;
   } sgc_pix_t;

   typedef enum logic [2:0]
   {
      ST_LOAD = 3'b000,
      ST_IDLE = 3'b001,
      ST_ACCUM = 3'b010,
      ST_MAXF = 3'b011,
      ST_DIV = 3'b100,
      ST_COPY = 3'b101
   } sgc_state_t;
endpackage

// *** sgc_divider.sv ***
// sequential restoring divider
module sgc_divider #(
   parameter int NW = 24,
   parameter int DW = 12
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic start,
   input wire logic [NW-1:0] num,
   input wire logic [DW-1:0] den,
   output logic busy,
   output logic done,
   output logic [NW-1:0] quot
);
   localparam int CW = $clog2(NW + 1);
   logic [DW:0] rem;
   logic [NW-1:0] num_r;
   logic [DW-1:0] den_r;
   logic [CW-1:0] cnt;
   logic [DW:0] rem_sh;

   assign rem_sh = {rem[DW-1:0], num_r[NW-1]};

   // zero divisor yields all ones, which the caller clamps
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rem <= '0;
         num_r <= '0;
         den_r <= '0;
         cnt <= '0;
         busy <= 1'b0;
         done <= 1'b0;
         quot <= '0;
      end
      else
      begin
         done <= 1'b0;
         if (start && !busy)
         begin
            rem <= '0;
            num_r <= num;
            den_r <= den;
            cnt <= CW'(NW);
            busy <= 1'b1;
         end
         else if (busy)
         begin
            num_r <= {num_r[NW-2:0], 1'b0};
            if (rem_sh >= {1'b0, den_r})
            begin
               rem <= rem_sh - {1'b0, den_r};
               quot <= {quot[NW-2:0], 1'b1};
            end
            else
            begin
               rem <= rem_sh;
               quot <= {quot[NW-2:0], 1'b0};
            end
            cnt <= cnt - CW'(1);
            if (cnt == CW'(1))
            begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule

// *** sgc_gain_cal.sv ***
// per-pixel gain calibration, file activation and gain correction
`include "sgc_consts.svh"
module sgc_gain_cal #(
   parameter int IW = 4
) (
   input wire logic clk,
   input wire logic rstn,
   input wire sgc_pkg::sgc_pix_t pix_in,
   input wire logic [`SGC_PIX_W-1:0] dark_offset,
   input wire logic single_line_mode,
   input wire logic [IW-1:0] roi_first,
   input wire logic [IW-1:0] roi_last,
   input wire logic [1:0] shading_mode,
   input wire logic cal_start,
   input wire logic cal_with_offset,
   input wire logic act_write,
   input wire logic act_select_user,
   input wire logic cmd_valid,
   output logic cmd_ack,
   output sgc_pkg::sgc_pix_t pix_out,
   output logic cal_busy,
   output logic active_is_user,
   output logic user_values_present
);
   localparam int NPIX = 2 ** IW;
   localparam int PW = `SGC_PIX_W;
   localparam int GW = `SGC_GAIN_W;
   localparam int AW = PW + `SGC_NCAL_LOG;
   localparam int NW = PW + `SGC_GAIN_FRAC;
   sgc_pkg::sgc_state_t state;
   logic [IW-1:0] idx;
   logic [IW-1:0] pix_idx;
   logic lval_d;
   logic armed;
   logic [`SGC_NCAL_LOG-1:0] line_cnt;
   logic area;
   logic with_off;
   logic div_pend;
   logic [PW-1:0] max_avg;
   logic [AW-1:0] acc [NPIX];
   logic [GW-1:0] user_file [2][NPIX];
   logic [GW-1:0] work_gain [2][NPIX];
   // non-volatile selection: deliberately untouched by reset
   logic nv_active_user = 1'b0;
   logic nv_user_present = 1'b0;
   logic line_start;
   logic line_end;
   logic acc_en;
   logic in_roi;
   logic [PW-1:0] samp;
   logic [PW-1:0] off_sub;
   logic [PW-1:0] avg_idx;
   logic div_start;
   logic div_busy;
   logic div_done;
   logic [NW-1:0] div_quot;
   logic [GW-1:0] gain_new;
   logic [GW-1:0] gain_use;
   logic [PW-1:0] corr_in;
   logic [PW+GW-1:0] prod;
   logic [PW+GW-1:0] prod_sh;
   assign line_start = pix_in.lval && !lval_d;
   assign line_end = lval_d && !pix_in.lval;
   assign acc_en = (state == sgc_pkg::ST_ACCUM) && (armed || line_start);
   assign in_roi = (idx >= roi_first) && (idx <= roi_last);
   assign off_sub = (pix_in.data > dark_offset) ? pix_in.data - dark_offset : '0;
   assign samp = with_off ? off_sub : pix_in.data; // [R05]
   assign avg_idx = PW'(acc[idx] >> `SGC_NCAL_LOG); // [R11]
   assign div_start = (state == sgc_pkg::ST_DIV) && in_roi && !div_pend;
   // gain = reference / own average, clamped to the gain range [R13]
   assign gain_new = (div_quot > NW'(`SGC_GAIN_MAX)) ? `SGC_GAIN_MAX : GW'(div_quot);
   sgc_divider #(
      .NW(NW),
      .DW(PW)
   ) u_div (
      .clk(clk),
      .rstn(rstn),
      .start(div_start),
      .num({max_avg, {`SGC_GAIN_FRAC{1'b0}}}),
      .den(avg_idx),
      .busy(div_busy),
      .done(div_done),
      .quot(div_quot)
   );
   // pixel position within the incoming line
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         lval_d <= 1'b0;
         pix_idx <= '0;
      end
      else
      begin
         lval_d <= pix_in.lval;
         if (!pix_in.lval)
            pix_idx <= '0;
         else if (pix_in.dval)
            pix_idx <= pix_idx + IW'(1);
      end
   end

   // sequencer: reload, accumulate, reference search, divide, activate
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= sgc_pkg::ST_LOAD; // [R18]
         idx <= '0;
         armed <= 1'b0;
         line_cnt <= '0;
         area <= 1'b0;
         with_off <= 1'b0;
         div_pend <= 1'b0;
         max_avg <= '0;
      end
      else
      begin
         case (state)
            sgc_pkg::ST_LOAD:
            begin
               idx <= idx + IW'(1);
               if (idx == IW'(NPIX - 1))
                  state <= sgc_pkg::ST_IDLE;
            end
            sgc_pkg::ST_IDLE:
            begin
               idx <= '0;
               if (cal_start)
               begin
                  state <= sgc_pkg::ST_ACCUM; // [R04]
                  area <= single_line_mode; // [R01]
                  with_off <= cal_with_offset; // [R04]
                  line_cnt <= '0;
                  armed <= 1'b0;
                  max_avg <= '0;
               end
               else if (act_write && (nv_user_present || !act_select_user))
                  state <= sgc_pkg::ST_COPY; // [R19]
            end
            sgc_pkg::ST_ACCUM:
            begin
               // only whole lines that begin after the request count
               if (line_start)
                  armed <= 1'b1;
               if (line_end && armed)
               begin
                  line_cnt <= line_cnt + `SGC_NCAL_LOG'(1);
                  if (line_cnt == `SGC_NCAL_LAST)
                  begin
                     state <= sgc_pkg::ST_MAXF; // [R06]
                     armed <= 1'b0;
                  end
               end
            end
            sgc_pkg::ST_MAXF:
            begin
               if (in_roi && (avg_idx > max_avg))
                  max_avg <= avg_idx; // [R12]
               idx <= idx + IW'(1);
               if (idx == IW'(NPIX - 1))
                  state <= sgc_pkg::ST_DIV;
            end
            sgc_pkg::ST_DIV:
            begin
               if (div_start)
                  div_pend <= 1'b1;
               if (!in_roi || div_done)
               begin
                  div_pend <= 1'b0;
                  idx <= idx + IW'(1);
                  if (idx == IW'(NPIX - 1))
                     state <= sgc_pkg::ST_COPY; // [R15]
               end
            end
            sgc_pkg::ST_COPY:
            begin
               idx <= idx + IW'(1);
               if (idx == IW'(NPIX - 1))
                  state <= sgc_pkg::ST_IDLE;
            end
            default:
               state <= sgc_pkg::ST_IDLE;
         endcase
      end
   end

   // per-pixel sums; first counted line loads, later ones add
   always_ff @(posedge clk)
   begin
      if (acc_en && pix_in.lval && pix_in.dval)
      begin
         if (line_cnt == '0)
            acc[pix_idx] <= AW'(samp); // [R06]
         else
            acc[pix_idx] <= acc[pix_idx] + AW'(samp); // [R11]
      end
   end

   // user file in storage: no reset, it outlives power cycles
   always_ff @(posedge clk)
   begin
      if (state == sgc_pkg::ST_DIV)
      begin
         if (!nv_user_present)
            user_file[~area][idx] <= work_gain[~area][idx]; // [R01]
         if (!in_roi)
            user_file[area][idx] <= work_gain[area][idx]; // [R03]
         else if (div_done)
            user_file[area][idx] <= gain_new; // [R02] [R14]
      end
   end

   // activated selection and presence of user values
   always_ff @(posedge clk)
   begin
      if (state == sgc_pkg::ST_DIV && idx == IW'(NPIX - 1) && (!in_roi || div_done))
      begin
         nv_active_user <= 1'b1; // [R15]
         nv_user_present <= 1'b1;
      end
      else if (state == sgc_pkg::ST_IDLE && !cal_start && act_write)
      begin
         if (!act_select_user)
            nv_active_user <= 1'b0; // [R16]
         else if (nv_user_present)
            nv_active_user <= 1'b1; // [R16]
      end
   end

   // working memory follows the activated file, both areas at once
   always_ff @(posedge clk)
   begin
      if (state == sgc_pkg::ST_COPY || state == sgc_pkg::ST_LOAD)
      begin
         for (int a = 0; a < 2; a++)
         begin
            work_gain[a][idx] <= nv_active_user ? user_file[a][idx] : `SGC_GAIN_ONE; // [R17] [R18]
         end
      end
   end

   // correction path; gain read from working memory of current area
   always_comb
   begin
      corr_in = shading_mode[`SGC_MODE_OFF_BIT] ? off_sub : pix_in.data; // [R20]
      gain_use = shading_mode[`SGC_MODE_GAIN_BIT] ? work_gain[single_line_mode][pix_idx]
         : `SGC_GAIN_ONE; // [R20]
      prod = (PW + GW)'(corr_in) * (PW + GW)'(gain_use); // [R21]
      prod_sh = prod >> `SGC_GAIN_FRAC;
   end

   // valids pass untouched during calibration; receiver drops data
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         pix_out <= '0;
      else
      begin
         pix_out.lval <= pix_in.lval; // [R08]
         pix_out.dval <= pix_in.dval; // [R08]
         pix_out.data <= (prod_sh > (PW + GW)'(`SGC_PIX_MAX)) ? `SGC_PIX_MAX : PW'(prod_sh);
      end
   end

   // command link stays silent while lines are collected
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cmd_ack <= 1'b0;
         cal_busy <= 1'b0;
         active_is_user <= 1'b0;
         user_values_present <= 1'b0;
      end
      else
      begin
         cmd_ack <= cmd_valid && (state == sgc_pkg::ST_IDLE) && !cal_start; // [R09]
         cal_busy <= (state != sgc_pkg::ST_IDLE) || cal_start;
         active_is_user <= nv_active_user;
         user_values_present <= nv_user_present;
      end
   end

   sequence s_gen_done;
      (state == sgc_pkg::ST_DIV) ##1 (state == sgc_pkg::ST_COPY);
   endsequence

   property p_no_ack_busy;
      @(posedge clk) disable iff (!rstn) (state != sgc_pkg::ST_IDLE) |=> !cmd_ack;
   endproperty
   a_no_ack_busy: assert property (p_no_ack_busy) else $error("ack while calibrating"); // [R09]
   property p_start;
      @(posedge clk) disable iff (!rstn)
         (state == sgc_pkg::ST_IDLE && cal_start) |=> (state == sgc_pkg::ST_ACCUM);
   endproperty
   a_start: assert property (p_start) else $error("calibration did not start"); // [R04]
   property p_count;
      @(posedge clk) disable iff (!rstn)
         (state == sgc_pkg::ST_ACCUM ##1 state == sgc_pkg::ST_MAXF)
         |-> $past(line_cnt) == `SGC_NCAL_LAST;
   endproperty
   a_count: assert property (p_count) else $error("too few lines collected"); // [R06]
   property p_valid_pass;
      @(posedge clk) disable iff (!rstn)
         ##1 (pix_out.lval == $past(pix_in.lval)) && (pix_out.dval == $past(pix_in.dval));
   endproperty
   a_valid_pass: assert property (p_valid_pass) else $error("valids not passed"); // [R08]
   property p_gen_active;
      @(posedge clk) disable iff (!rstn) s_gen_done |=> active_is_user && user_values_present;
   endproperty
   a_gen_active: assert property (p_gen_active) else $error("user file not activated"); // [R15]
   property p_factory_sel;
      @(posedge clk) disable iff (!rstn)
         (state == sgc_pkg::ST_IDLE && !cal_start && act_write && !act_select_user)
         |=> ##1 !active_is_user;
   endproperty
   a_factory_sel: assert property (p_factory_sel) else $error("factory not selected"); // [R16]

   property p_copy_end;
      @(posedge clk) disable iff (!rstn)
         (state == sgc_pkg::ST_COPY && idx == IW'(NPIX - 1)) |=> (state == sgc_pkg::ST_IDLE);
   endproperty
   a_copy_end: assert property (p_copy_end) else $error("copy overran"); // [R17]

   property p_outside_roi;
      @(posedge clk) disable iff (!rstn)
         (state == sgc_pkg::ST_DIV && !in_roi) |-> !div_start ##1 !div_busy;
   endproperty
   a_outside_roi: assert property (p_outside_roi) else $error("gain computed outside roi"); // [R02]

   property p_gain_off;
      @(posedge clk) disable iff (!rstn)
         (shading_mode == 2'h0) |=> pix_out.data == $past(pix_in.data);
   endproperty
   a_gain_off: assert property (p_gain_off) else $error("data altered with correction off"); // [R21]
endmodule

// *** sgc_line_src.sv ***
// line source model driving the sensor pixel stream
module sgc_line_src (
   input wire logic clk,
   output sgc_pkg::sgc_pix_t pix
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] junk = 12'hA5A;
   initial pix = '0;
   // one line of 16 pixels, then an idle gap
   task automatic send_line(input logic [11:0] ln [16]);
      for (int k = 0; k < 16; k++)
      begin
         @(posedge clk);
         pix <= '{1'b1, 1'b1, ln[k]};
      end
      // idle data keeps toggling so stale pixels never look valid
      repeat (4)
      begin
         @(posedge clk);
         junk = ~junk;
         pix <= '{1'b0, 1'b0, junk};
      end
   endtask
endmodule

// *** test_sgc_gain_cal.sv ***
// self-checking bench of the gain calibration engine
`include "sgc_consts.svh"
module test_sgc_gain_cal;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [11:0] d; bit care;} sgc_note_t;
   logic clk = 0;
   logic rstn = 0;
   logic slm = 0;
   logic cal_start = 0;
   logic cal_off = 0;
   logic act_write = 0;
   logic act_user = 0;
   logic cmd_valid = 0;
   logic cmd_ack, cal_busy, act_is_user, user_present;
   logic [11:0] off = 0;
   logic [3:0] roi_f = 0;
   logic [3:0] roi_l = 4'hF;
   logic [1:0] mode = 0;
   sgc_pkg::sgc_pix_t pix_in, pix_out;
   logic [15:0] gm [16];
   logic [15:0] gu [16];
   logic [11:0] ln [16];
   sgc_note_t q [$];
   sgc_note_t e;
   int num_errors = 0;
   int num_checks = 0;

   initial
   begin
      forever #5 clk = ~clk;
   end

   sgc_gain_cal i_dut (.clk(clk), .rstn(rstn), .pix_in(pix_in), .dark_offset(off),
      .single_line_mode(slm), .roi_first(roi_f), .roi_last(roi_l), .shading_mode(mode),
      .cal_start(cal_start), .cal_with_offset(cal_off), .act_write(act_write),
      .act_select_user(act_user), .cmd_valid(cmd_valid), .cmd_ack(cmd_ack),
      .pix_out(pix_out), .cal_busy(cal_busy), .active_is_user(act_is_user),
      .user_values_present(user_present));

   sgc_line_src src (.clk(clk), .pix(pix_in));

   task automatic fail(input string m);
      num_errors++;
      $display("CHECK FAILED t=%0t %s", $time, m);
   endtask

   task automatic check_bit(input logic a, input logic x, input string m);
      num_checks++;
      if (a !== x) fail(m);
   endtask

   task automatic check_pix(input logic [11:0] a, input logic [11:0] x);
      num_checks++;
      if (a !== x) fail($sformatf("pixel %h expected %h", a, x));
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   function automatic logic [11:0] corr(logic [11:0] d, logic [15:0] g);
      logic [27:0] p;
      p = d;
      if (mode[`SGC_MODE_OFF_BIT]) p = d - off;
      if (mode[`SGC_MODE_GAIN_BIT]) p = (p * g) >> `SGC_GAIN_FRAC;
      return (p > `SGC_PIX_MAX) ? `SGC_PIX_MAX : p[11:0];
   endfunction

   // values stay far above the offset so no sample underflows
   task automatic rnd_line();
      for (int k = 0; k < 16; k++) ln[k] = 12'h200 + 12'($urandom_range(12'h5FF));
   endtask

   task automatic wait_idle();
      int n = 0;
      repeat (3) @(posedge clk);
      while (cal_busy !== 1'b0 && n < 3000)
      begin
         @(posedge clk);
         n++;
      end
      #1 check_bit(cal_busy, 0, "stuck busy");
   endtask

   task automatic probe(input logic x);
      @(posedge clk);
      cmd_valid <= 1;
      @(posedge clk);
      cmd_valid <= 0;
      #1 check_bit(cmd_ack, x, "command ack");
   endtask

   task automatic pulse_act(input logic u);
      @(posedge clk);
      act_write <= 1;
      act_user <= u;
      @(posedge clk);
      act_write <= 0;
      wait_idle();
   endtask

   // model of the new gain set; outside the region old gains stay
   task automatic learn(input logic wo);
      logic [11:0] a [16];
      logic [11:0] mx;
      logic [27:0] g;
      mx = 0;
      for (int k = 0; k < 16; k++) a[k] = wo ? ln[k] - off : ln[k];
      for (int k = roi_f; k <= roi_l; k++) if (a[k] > mx) mx = a[k];
      for (int k = roi_f; k <= roi_l; k++)
      begin
         g = (28'(mx) << `SGC_GAIN_FRAC) / a[k];
         gm[k] = (g > `SGC_GAIN_MAX) ? `SGC_GAIN_MAX : g[15:0];
      end
   endtask

   task automatic calibrate(input logic wo);
      @(posedge clk);
      cal_start <= 1;
      cal_off <= wo;
      @(posedge clk);
      cal_start <= 0;
      #1 check_bit(cal_busy, 1, "busy after start");
      probe(0);
      for (int l = 0; l < `SGC_NCAL; l++)
      begin
         for (int k = 0; k < 16; k++) q.push_back('{12'h0, 1'b0});
         src.send_line(ln);
      end
      wait_idle();
      check_bit(user_present, 1, "user values stored");
      check_bit(act_is_user, 1, "user file active");
      learn(wo);
   endtask

   task automatic stream();
      for (int m = 0; m < 4; m++)
      begin
         @(posedge clk);
         mode <= m[1:0];
         @(posedge clk);
         rnd_line();
         for (int k = 0; k < 16; k++) q.push_back('{corr(ln[k], gm[k]), 1'b1});
         src.send_line(ln);
      end
   endtask

   always @(posedge clk)
   begin
      if (pix_out.dval === 1'b1)
      begin
         if (q.size() == 0)
            fail("unexpected pixel");
         else
         begin
            e = q.pop_front();
            check_bit(pix_out.lval, 1, "line valid");
            if (e.care) check_pix(pix_out.data, e.d);
         end
      end
   end

   initial
   begin
      #400000;
      fail("timeout");
      stop_test();
   end

   initial
   begin
      void'($urandom(32'h3044));
      off <= 12'($urandom_range(255));
      for (int k = 0; k < 16; k++) gm[k] = `SGC_GAIN_ONE;
      repeat (5) @(posedge clk);
      rstn <= 1;
      wait_idle();
      check_bit(act_is_user, 0, "factory at power-up");
      check_bit(user_present, 0, "no user values");
      pulse_act(1);
      check_bit(act_is_user, 0, "user refused");
      stream();
      probe(1);
      rnd_line();
      calibrate(0);
      stream();
      @(posedge clk);
      roi_f <= 4'h4;
      roi_l <= 4'h9;
      rnd_line();
      calibrate(1);
      stream();
      // reset in mid-run must bring the user gains back
      @(posedge clk);
      rstn <= 0;
      repeat (2) @(posedge clk);
      rstn <= 1;
      wait_idle();
      check_bit(act_is_user, 1, "link kept over reset");
      stream();
      pulse_act(0);
      check_bit(act_is_user, 0, "factory active");
      gu = gm;
      for (int k = 0; k < 16; k++) gm[k] = `SGC_GAIN_ONE;
      stream();
      // single-line area learns its own gains, the other area keeps its set
      @(posedge clk);
      slm <= 1;
      rnd_line();
      calibrate(0);
      stream();
      @(posedge clk);
      slm <= 0;
      gm = gu;
      stream();
      repeat (4) @(posedge clk);
      check_bit(q.size() == 0, 1, "missing pixels");
      stop_test();
   end
endmodule
